// >>> hw/phy_cfg_pkg.sv
// constants for the fault, interrupt mask and reset configuration bank
// assumes a 25 MHz system clock and byte-wide registers on the serial port
package phy_cfg_pkg;

  // ---------------------------------------------------------------
  // register addresses and widths
  // ---------------------------------------------------------------
  localparam int          ADDR_W           = 7;
  localparam int          DATA_W           = 8;
  localparam int          FRAME_W          = 16;
  localparam logic [6:0]  ADDR_AUX_OVC     = 7'h06;
  localparam logic [6:0]  ADDR_REVISION    = 7'h07;
  localparam logic [6:0]  ADDR_IRQ_MASK    = 7'h08;
  localparam logic [6:0]  ADDR_RST_SETUP   = 7'h09;

  // ---------------------------------------------------------------
  // reset values and field layout
  // ---------------------------------------------------------------
  localparam logic [7:0]  AUX_OVC_RESET    = 8'h20;
  localparam logic [7:0]  IRQ_MASK_RESET   = 8'h00;
  localparam logic [1:0]  RST_SEL_RESET    = 2'h0;
  localparam logic [7:0]  IRQ_MASK_WR      = 8'hFB;
  localparam int          OVC_RETRY_EN_BIT = 0;
  localparam int          OVC_RETRY_LSB    = 1;
  localparam int          OVC_BLANK_LSB    = 3;
  localparam int          RST_SEL_LSB      = 6;
  localparam int          RST_POL_BIT      = 5;
  localparam logic        RST_POL_VALUE    = 1'b0;
  localparam logic [1:0]  BLANK_NONE       = 2'h3;
  localparam logic [1:0]  RST_SEL_BOTH     = 2'h0;
  localparam logic [1:0]  RST_SEL_LINE     = 2'h1;
  localparam logic [1:0]  RST_SEL_REG      = 2'h2;
  localparam logic [4:0]  BITS_CMD         = 5'h08;
  localparam logic [4:0]  BITS_LAST        = 5'h0F;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int          CLK_MHZ          = 25;
  localparam int          BLANK0_US        = 200;
  localparam int          BLANK1_US        = 500;
  localparam int          BLANK2_MS        = 5;
  localparam int          RETRY0_MS        = 50;
  localparam int          RETRY1_MS        = 100;
  localparam int          RETRY2_MS        = 200;
  localparam int          RETRY3_MS        = 500;
  localparam int          TIMER_W          = 24;

endpackage

// >>> hw/phy_fault_irq_reset_config.sv
// fault, interrupt mask and reset output configuration bank
// assumes all pins synchronous to clk_sys; serial port in mode 0
`timescale 1ns/100ps
`default_nettype none
module phy_fault_irq_reset_config
  import phy_cfg_pkg::*;
#(
  parameter int unsigned BLANK0_CYC = BLANK0_US * CLK_MHZ,
  parameter int unsigned BLANK1_CYC = BLANK1_US * CLK_MHZ,
  parameter int unsigned BLANK2_CYC = BLANK2_MS * 1000 * CLK_MHZ,
  parameter int unsigned RETRY0_CYC = RETRY0_MS * 1000 * CLK_MHZ,
  parameter int unsigned RETRY1_CYC = RETRY1_MS * 1000 * CLK_MHZ,
  parameter int unsigned RETRY2_CYC = RETRY2_MS * 1000 * CLK_MHZ,
  parameter int unsigned RETRY3_CYC = RETRY3_MS * 1000 * CLK_MHZ,
  parameter logic [2:0]  REVISION   = 3'h5  // arbitrary value
) (
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  input  wire logic        spi_cs_n,
  input  wire logic        spi_sclk,
  input  wire logic        spi_mosi,
  output logic             spi_miso_q,
  input  wire logic        aux_overcurrent,
  output logic             aux_drive_q,
  output logic             aux_fault_pulse_q,
  output logic [2:0]       aux_out_current_limit_code_q,
  input  wire logic [7:0]  irq_status,
  output logic             irq_pin_q,
  input  wire logic        line_supply_undervoltage,
  input  wire logic        regulator_output_undervoltage,
  output logic             reset_out_q
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [TIMER_W-1:0] blank_limit(input logic [1:0] c);
    case (c)
      2'h0:    blank_limit = TIMER_W'(BLANK0_CYC - 1);
      2'h1:    blank_limit = TIMER_W'(BLANK1_CYC - 1);
      default: blank_limit = TIMER_W'(BLANK2_CYC - 1);
    endcase
  endfunction

  function automatic logic [TIMER_W-1:0] retry_limit(input logic [1:0] c);
    case (c)
      2'h0:    retry_limit = TIMER_W'(RETRY0_CYC - 1);
      2'h1:    retry_limit = TIMER_W'(RETRY1_CYC - 1);
      2'h2:    retry_limit = TIMER_W'(RETRY2_CYC - 1);
      default: retry_limit = TIMER_W'(RETRY3_CYC - 1);
    endcase
  endfunction

  // ---------------------------------------------------------------
  // serial port
  // ---------------------------------------------------------------
  logic                sclk_prev_q;
  logic [4:0]          bit_cnt_q;
  logic [FRAME_W-2:0]  shift_q;
  logic [DATA_W-1:0]   tx_q;
  wire                 sclk_rise = spi_sclk & ~sclk_prev_q & ~spi_cs_n;
  wire                 sclk_fall = ~spi_sclk & sclk_prev_q & ~spi_cs_n;
  wire [FRAME_W-1:0]   frame     = {shift_q, spi_mosi};
  wire                 wr_done   = sclk_rise & (bit_cnt_q == BITS_LAST)
                                   & frame[FRAME_W-1];
  wire [ADDR_W-1:0]    wr_addr   = frame[FRAME_W-2:DATA_W];
  wire [DATA_W-1:0]    wr_data   = frame[DATA_W-1:0];
  wire [ADDR_W-1:0]    rd_addr   = shift_q[ADDR_W-1:0];
  wire                 load_tx   = sclk_fall & (bit_cnt_q == BITS_CMD);
  wire                 wr_ovc    = wr_done & (wr_addr == ADDR_AUX_OVC);
  wire                 wr_mask   = wr_done & (wr_addr == ADDR_IRQ_MASK);
  wire                 wr_rst    = wr_done & (wr_addr == ADDR_RST_SETUP);

  logic [7:0]          ovc_q;
  logic [7:0]          mask_q;
  logic [1:0]          rst_sel_q;
  logic [7:0]          rd_data;

  // register read mux; unmapped addresses read zero
  wire [7:0] rev_word = {5'h00, REVISION};
  wire [7:0] rst_word = {rst_sel_q, RST_POL_VALUE, 5'h00};
  always_comb begin
    case (rd_addr)
      ADDR_AUX_OVC:   rd_data = ovc_q;
      ADDR_REVISION:  rd_data = rev_word;
      ADDR_IRQ_MASK:  rd_data = mask_q;
      ADDR_RST_SETUP: rd_data = rst_word;
      default:        rd_data = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sclk_prev_q <= 1'b0;
      bit_cnt_q   <= 5'h00;
      shift_q     <= '0;
      tx_q        <= 8'h00;
      spi_miso_q  <= 1'b0;
    end else begin
      sclk_prev_q <= spi_sclk;
      if (spi_cs_n) begin
        bit_cnt_q  <= 5'h00;
        spi_miso_q <= 1'b0;
      end else if (sclk_rise) begin
        bit_cnt_q <= bit_cnt_q + 5'h01;
        shift_q   <= frame[FRAME_W-2:0];
      end else if (load_tx) begin
        spi_miso_q <= rd_data[DATA_W-1];
        tx_q       <= {rd_data[DATA_W-2:0], 1'b0};
      end else if (sclk_fall && bit_cnt_q > BITS_CMD) begin
        spi_miso_q <= tx_q[DATA_W-1];
        tx_q       <= {tx_q[DATA_W-2:0], 1'b0};
      end
    end
  end

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ovc_q     <= AUX_OVC_RESET;
      mask_q    <= IRQ_MASK_RESET;
      rst_sel_q <= RST_SEL_RESET;
    end else begin
      if (wr_ovc)
        ovc_q <= wr_data;
      if (wr_mask)
        mask_q <= wr_data & IRQ_MASK_WR;
      if (wr_rst)
        rst_sel_q <= wr_data[RST_SEL_LSB +: 2];
    end
  end

  // ---------------------------------------------------------------
  // auxiliary output overcurrent handling
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {ST_ON, ST_BLANK, ST_OFF} ovc_state_type;
  ovc_state_type       state_q;
  ovc_state_type       state_d;
  logic [TIMER_W-1:0]  tim_q;
  logic [TIMER_W-1:0]  tim_d;
  logic                fault_d;
  wire [1:0]           blank_code = ovc_q[OVC_BLANK_LSB +: 2];
  wire [1:0]           retry_code = ovc_q[OVC_RETRY_LSB +: 2];
  wire                 retry_en   = ovc_q[OVC_RETRY_EN_BIT];

  // a latched shutdown without retry is released by rewriting the setup
  always_comb begin
    state_d = state_q;
    tim_d   = tim_q;
    fault_d = 1'b0;
    case (state_q)
      ST_ON: begin
        tim_d = '0;
        if (aux_overcurrent && blank_code == BLANK_NONE) begin
          state_d = ST_OFF;
          fault_d = 1'b1;
        end else if (aux_overcurrent) begin
          state_d = ST_BLANK;
        end
      end
      ST_BLANK: begin
        if (!aux_overcurrent) begin
          state_d = ST_ON;
          tim_d   = '0;
        end else if (tim_q == blank_limit(blank_code)) begin
          state_d = ST_OFF;
          tim_d   = '0;
          fault_d = 1'b1;
        end else begin
          tim_d = tim_q + 1'b1;
        end
      end
      ST_OFF: begin
        if (retry_en && tim_q == retry_limit(retry_code)) begin
          state_d = ST_ON;
          tim_d   = '0;
        end else if (retry_en) begin
          tim_d = tim_q + 1'b1;
        end else begin
          tim_d = '0;
          if (wr_ovc)
            state_d = ST_ON;
        end
      end
      default: begin
        state_d = ST_OFF;
        tim_d   = '0;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // interrupt pin and reset output
  // ---------------------------------------------------------------
  wire irq_any = |(irq_status & ~mask_q);
  wire uv_hit  = (rst_sel_q == RST_SEL_LINE) ? line_supply_undervoltage :
                 (rst_sel_q == RST_SEL_REG)  ? regulator_output_undervoltage :
                 (line_supply_undervoltage | regulator_output_undervoltage);

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_q                      <= ST_ON;
      tim_q                        <= '0;
      aux_drive_q                  <= 1'b0;
      aux_fault_pulse_q            <= 1'b0;
      aux_out_current_limit_code_q <= AUX_OVC_RESET[7:5];
      irq_pin_q                    <= 1'b0;
      reset_out_q                  <= 1'b1;
    end else begin
      state_q                      <= state_d;
      tim_q                        <= tim_d;
      aux_drive_q                  <= (state_d != ST_OFF);
      aux_fault_pulse_q            <= fault_d;
      aux_out_current_limit_code_q <= ovc_q[7:5];
      irq_pin_q                    <= irq_any;
      reset_out_q                  <= uv_hit ~^ RST_POL_VALUE;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  irq_masked_a: assert property ((irq_status & ~mask_q) == 8'h00
    |=> !irq_pin_q) else $error("masked source reached the pin");
  irq_pin_a: assert property ((|(irq_status & ~mask_q)) |=> irq_pin_q)
    else $error("unmasked flag did not raise the pin");
  mask_rsvd_a: assert property (!mask_q[2])
    else $error("reserved mask bit set");
  mask_write_a: assert property (wr_mask
    |=> mask_q == $past(wr_data & IRQ_MASK_WR))
    else $error("mask write not taken");
  rev_read_a: assert property (rd_addr == ADDR_REVISION
    |-> rd_data[7:3] == 5'h00 && rd_data[2:0] == REVISION)
    else $error("revision read wrong");
  pol_ro_a: assert property (rd_addr == ADDR_RST_SETUP |-> !rd_data[5])
    else $error("polarity bit not zero");
  rst_line_a: assert property (rst_sel_q == RST_SEL_LINE
    && line_supply_undervoltage |=> !reset_out_q)
    else $error("line undervoltage missed reset");
  rst_reg_only_a: assert property (rst_sel_q == RST_SEL_REG
    && !regulator_output_undervoltage |=> reset_out_q)
    else $error("reset asserted by unselected source");
  blank_none_a: assert property (state_q == ST_ON && aux_overcurrent
    && blank_code == BLANK_NONE |=> !aux_drive_q && aux_fault_pulse_q)
    else $error("no-blanking shutdown late");
  blank_hold_a: assert property (state_q == ST_BLANK
    && tim_q < blank_limit(blank_code) |=> aux_drive_q)
    else $error("driver cut inside blanking");
  retry_off_a: assert property (state_q == ST_OFF && !retry_en
    && !wr_ovc |=> !aux_drive_q) else $error("retry while disabled");
  retry_back_a: assert property (state_q == ST_OFF && retry_en
    && tim_q == retry_limit(retry_code) |=> aux_drive_q ##0 state_q == ST_ON)
    else $error("retry not taken at end of wait");

endmodule
`default_nettype wire

// >>> testbench/spi_ctrl_model.sv
// serial controller model: 16-bit frames, mode 0, msb first
// assumes the bench clock; every change lands on its falling edge
`timescale 1ns/100ps
`default_nettype none
module spi_ctrl_model (
  input  wire logic clk_sys,
  input  wire logic spi_miso_q,
  output logic      spi_cs_n,
  output logic      spi_sclk,
  output logic      spi_mosi
);
  // ---------------------------------------------------------------
  // frame task, three system clocks per serial phase
  // ---------------------------------------------------------------
  initial begin
    spi_cs_n = 1'b1;
    spi_sclk = 1'b0;
    spi_mosi = 1'b0;
  end

  task automatic xfer(input logic wr, input logic [6:0] addr,
                      input logic [7:0] wdata, output logic [7:0] rdata);
    logic [15:0] frame;
    frame = {wr, addr, wdata};
    rdata = 8'h00;
    @(negedge clk_sys);
    spi_cs_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      spi_mosi = frame[i];
      repeat (3) @(negedge clk_sys);
      if (i < 8) rdata[i] = spi_miso_q;
      spi_sclk = 1'b1;
      repeat (3) @(negedge clk_sys);
      spi_sclk = 1'b0;
    end
    repeat (3) @(negedge clk_sys);
    spi_cs_n = 1'b1;
    // idle data line must not keep the last bit
    spi_mosi = ~spi_mosi;
    repeat (2) @(negedge clk_sys);
  endtask
endmodule
`default_nettype wire

// >>> testbench/testbench.sv
// self-checking bench for the configuration bank
// assumes spi_ctrl_model as the serial controller
`timescale 1ns/100ps
`default_nettype none
module testbench
  import phy_cfg_pkg::*;
;
  // ---------------------------------------------------------------
  // signals, design and controller
  // ---------------------------------------------------------------
  localparam logic [2:0] REV = 3'h5;  // arbitrary value
  // shortened blanking and retry waits, in system clocks
  localparam int unsigned BL0 = 8;
  localparam int unsigned BL1 = 12;
  localparam int unsigned BL2 = 20;
  localparam int unsigned RT0 = 30;
  localparam int unsigned RT1 = 40;
  localparam int unsigned RT2 = 50;
  localparam int unsigned RT3 = 60;
  typedef struct packed {
    logic [6:0] addr;
    logic [7:0] wdata;
    logic [7:0] exp;
  } row_type;
  row_type    rows [7];
  int         blank [4] = '{BL0, BL1, BL2, 0};
  int         retry [4] = '{RT0, RT1, RT2, RT3};
  int         num_errors = 0;
  int         n_compared = 0;
  int         cycles = 0;
  logic       clk_sys = 1'b0;
  logic       arst_n = 1'b0;
  logic       cs_n, sclk, mosi, miso, ovc, drv, pulse, irq, lsu, rou, rst_q;
  logic       seen;
  logic [2:0] lim;
  logic [7:0] stat, rd;

  phy_fault_irq_reset_config #(
    .BLANK0_CYC(BL0), .BLANK1_CYC(BL1), .BLANK2_CYC(BL2), .RETRY0_CYC(RT0),
    .RETRY1_CYC(RT1), .RETRY2_CYC(RT2), .RETRY3_CYC(RT3), .REVISION(REV)
  ) DUT (
    .clk_sys(clk_sys), .arst_n(arst_n), .spi_cs_n(cs_n), .spi_sclk(sclk),
    .spi_mosi(mosi), .spi_miso_q(miso), .aux_overcurrent(ovc),
    .aux_drive_q(drv), .aux_fault_pulse_q(pulse),
    .aux_out_current_limit_code_q(lim), .irq_status(stat), .irq_pin_q(irq),
    .line_supply_undervoltage(lsu), .regulator_output_undervoltage(rou),
    .reset_out_q(rst_q)
  );
  spi_ctrl_model ctrl (.clk_sys(clk_sys), .spi_miso_q(miso),
    .spi_cs_n(cs_n), .spi_sclk(sclk), .spi_mosi(mosi));

  always #20 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (pulse === 1'b1) seen <= 1'b1;
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      conclude();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    ovc = 1'b0;
    stat = 8'h00;
    lsu = 1'b0;
    rou = 1'b0;
    rows = '{'{ADDR_REVISION, 8'hFF, {5'h00, REV}},
             '{ADDR_IRQ_MASK, 8'hFF, 8'hFB}, '{ADDR_IRQ_MASK, 8'h04, 8'h00},
             '{ADDR_RST_SETUP, 8'hFF, 8'hC0}, '{ADDR_RST_SETUP, 8'h5F, 8'h40},
             '{7'h0A, 8'hFF, 8'h00}, '{ADDR_AUX_OVC, 8'hFE, 8'hFE}};
    tick(10);
    arst_n = 1'b1;
    tick(1);
    foreach (rows[i]) begin
      ctrl.xfer(1'b1, rows[i].addr, rows[i].wdata, rd);
      ctrl.xfer(1'b0, rows[i].addr, 8'h00, rd);
      check(rd, rows[i].exp);
    end
    // second reset after the registers were changed
    arst_n = 1'b0;
    tick(10);
    arst_n = 1'b1;
    tick(2);
    check(8'(drv), 8'h01);
    check(8'(lim), 8'(AUX_OVC_RESET[7:5]));
    ctrl.xfer(1'b0, ADDR_AUX_OVC, 8'h00, rd);
    check(rd, AUX_OVC_RESET);
    ctrl.xfer(1'b0, ADDR_IRQ_MASK, 8'h00, rd);
    check(rd, IRQ_MASK_RESET);
    ctrl.xfer(1'b0, ADDR_RST_SETUP, 8'h00, rd);
    check(rd, 8'h00);
    for (int m = 0; m < 2; m++) begin
      if (m == 1) ctrl.xfer(1'b1, ADDR_IRQ_MASK, 8'hFF, rd);
      for (int b = 0; b < 8; b++) begin
        stat = 8'h01 << b;
        tick(3);
        check(8'(irq), 8'((m == 0) || (b == 2)));
      end
    end
    stat = 8'h00;
    for (int s = 0; s < 4; s++) begin
      ctrl.xfer(1'b1, ADDR_RST_SETUP, {s[1:0], 6'h00}, rd);
      for (int u = 0; u < 4; u++) begin
        {lsu, rou} = u[1:0];
        tick(3);
        check(8'(rst_q), 8'(!((s != 2 && lsu) || (s != 1 && rou))));
      end
    end
    for (int c = 0; c < 4; c++) begin
      ctrl.xfer(1'b1, ADDR_AUX_OVC, {1'b1, c[1:0], c[1:0], 3'h0}, rd);
      check(8'(drv), 8'h01);
      check(8'(lim), {5'h00, 1'b1, c[1:0]});
      seen = 1'b0;
      ovc = 1'b1;
      if (c < 3) begin
        tick(blank[c] - 2);
        check(8'(drv), 8'h01);
        ovc = 1'b0;
        tick(1);
        ovc = 1'b1;
        // blanking restarts after the drop
        tick(blank[c] - 1);
        check(8'(drv), 8'h01);
      end
      tick(4);
      check(8'(drv), 8'h00);
      check(8'(seen), 8'h01);
      ovc = 1'b0;
      tick(70);
      check(8'(drv), 8'h00);
    end
    for (int r = 0; r < 4; r++) begin
      // blanking stays nonzero while retry is on
      ctrl.xfer(1'b1, ADDR_AUX_OVC, {5'h04, r[1:0], 1'b1}, rd);
      ovc = 1'b1;
      tick(12);
      ovc = 1'b0;
      check(8'(drv), 8'h00);
      tick(retry[r] - 4);
      check(8'(drv), 8'h00);
      tick(2);
      check(8'(drv), 8'h01);
    end
    conclude();
  end
endmodule
`default_nettype wire
